// file: hdl/agm_regs.sv
`timescale 1ns/1ps
// What this block does
// - Right gain register bit 7 mutes the right amp when set; resets to one.
// - Right gain bits 6 to 0 set the amp gain in half-dB steps from 0 dB.
// - Gain codes from 0x77 up to 0x7F all give the top gain of 59.5 dB.
// - The right amp gain code resets to zero, which is 0 dB.
// - Left mix bits 7 to 4 set the second left input level, 0 to -12 dB.
// - Level codes 0 to 8 connect the input; 1111 disconnects and is reset.
// - Left mix bits 3 to 0 set the second right input level.
// - Right mix bits 7 to 4 set the second left input level.
// - Right mix bits 3 to 0 set the second right input level.
module agm_regs (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [6:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  output logic            right_amp_mute,
  output logic [6:0]      right_amp_gain,
  output logic            lmix_second_left_input_conn,
  output logic [3:0]      lmix_second_left_input_atten,
  output logic            lmix_second_right_input_conn,
  output logic [3:0]      lmix_second_right_input_atten,
  output logic            rmix_second_left_input_conn,
  output logic [3:0]      rmix_second_left_input_atten,
  output logic            rmix_second_right_input_conn,
  output logic [3:0]      rmix_second_right_input_atten
);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0] gain_ctrl_reg;
  logic [7:0] gain_ctrl_next;
  logic [7:0] left_mix_reg;
  logic [7:0] left_mix_next;
  logic [7:0] right_mix_reg;
  logic [7:0] right_mix_next;
  logic       wr_gain;
  logic       wr_left;
  logic       wr_right;

  assign wr_gain  = reg_wr && (reg_addr == agm_pkg::RIGHT_PGA_GAIN_CTRL);
  assign wr_left  = reg_wr && (reg_addr == agm_pkg::SECOND_IN_TO_LEFT);
  assign wr_right = reg_wr && (reg_addr == agm_pkg::SECOND_IN_TO_RIGHT);

  always_comb begin
    gain_ctrl_next = wr_gain  ? reg_wdata : gain_ctrl_reg;
    left_mix_next  = wr_left  ? reg_wdata : left_mix_reg;
    right_mix_next = wr_right ? reg_wdata : right_mix_reg;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gain_ctrl_reg <= agm_pkg::GAIN_CTRL_RST;
      left_mix_reg  <= agm_pkg::MIX_RST;
      right_mix_reg <= agm_pkg::MIX_RST;
    end else begin
      gain_ctrl_reg <= gain_ctrl_next;
      left_mix_reg  <= left_mix_next;
      right_mix_reg <= right_mix_next;
    end
  end

  // ---------------------------------------------------------------
  // Read back, one cycle after the read strobe
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= agm_pkg::UNMAPPED_RDATA;
    end else if (reg_rd) begin
      case (reg_addr)
        agm_pkg::RIGHT_PGA_GAIN_CTRL: reg_rdata <= gain_ctrl_reg;
        agm_pkg::SECOND_IN_TO_LEFT:   reg_rdata <= left_mix_reg;
        agm_pkg::SECOND_IN_TO_RIGHT:  reg_rdata <= right_mix_reg;
        default:                      reg_rdata <= agm_pkg::UNMAPPED_RDATA;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Field decode, fed from next values so outputs move with the write
  // ---------------------------------------------------------------
  logic [6:0] gain_dec;
  logic       ll_conn;
  logic [3:0] ll_att;
  logic       lr_conn;
  logic [3:0] lr_att;
  logic       rl_conn;
  logic [3:0] rl_att;
  logic       rr_conn;
  logic [3:0] rr_att;

  agm_gain_sat u_gain (
    .code (gain_ctrl_next[agm_pkg::GAIN_MSB:agm_pkg::GAIN_LSB]),
    .gain (gain_dec)
  );

  agm_level_decode u_lvl_ll (
    .code    (left_mix_next[agm_pkg::HI_LVL_MSB:agm_pkg::HI_LVL_LSB]),
    .connect (ll_conn),
    .atten   (ll_att)
  );

  agm_level_decode u_lvl_lr (
    .code    (left_mix_next[agm_pkg::LO_LVL_MSB:agm_pkg::LO_LVL_LSB]),
    .connect (lr_conn),
    .atten   (lr_att)
  );

  agm_level_decode u_lvl_rl (
    .code    (right_mix_next[agm_pkg::HI_LVL_MSB:agm_pkg::HI_LVL_LSB]),
    .connect (rl_conn),
    .atten   (rl_att)
  );

  agm_level_decode u_lvl_rr (
    .code    (right_mix_next[agm_pkg::LO_LVL_MSB:agm_pkg::LO_LVL_LSB]),
    .connect (rr_conn),
    .atten   (rr_att)
  );

  // ---------------------------------------------------------------
  // Front-end control outputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      right_amp_mute <= agm_pkg::GAIN_CTRL_RST[agm_pkg::MUTE_BIT];
      right_amp_gain <= 7'h00;
    end else begin
      right_amp_mute <= gain_ctrl_next[agm_pkg::MUTE_BIT];
      right_amp_gain <= gain_dec;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lmix_second_left_input_conn   <= 1'b0;
      lmix_second_left_input_atten  <= 4'h0;
      lmix_second_right_input_conn  <= 1'b0;
      lmix_second_right_input_atten <= 4'h0;
      rmix_second_left_input_conn   <= 1'b0;
      rmix_second_left_input_atten  <= 4'h0;
      rmix_second_right_input_conn  <= 1'b0;
      rmix_second_right_input_atten <= 4'h0;
    end else begin
      lmix_second_left_input_conn   <= ll_conn;
      lmix_second_left_input_atten  <= ll_att;
      lmix_second_right_input_conn  <= lr_conn;
      lmix_second_right_input_atten <= lr_att;
      rmix_second_left_input_conn   <= rl_conn;
      rmix_second_left_input_atten  <= rl_att;
      rmix_second_right_input_conn  <= rr_conn;
      rmix_second_right_input_atten <= rr_att;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_mute_follows_write: assert property (
    wr_gain |=> right_amp_mute == $past(reg_wdata[7])
  ) else $error("right amp mute does not follow the write");

  a_gain_in_range: assert property (
    (wr_gain && reg_wdata[6:0] <= 7'h77)
      |=> right_amp_gain == $past(reg_wdata[6:0])
  ) else $error("right amp gain differs from written code");

  a_gain_saturates: assert property (
    (wr_gain && reg_wdata[6:0] > 7'h77) |=> right_amp_gain == 7'h77
  ) else $error("right amp gain not clamped to 59.5 dB");

  a_gain_never_above: assert property (
    right_amp_gain <= 7'h77
  ) else $error("right amp gain above top step");

  a_reset_state: assert property (
    disable iff (1'b0)
    $rose(rst_n) |-> right_amp_mute && right_amp_gain == 7'h00
      && !lmix_second_left_input_conn && !rmix_second_right_input_conn
      && !lmix_second_right_input_conn && !rmix_second_left_input_conn
  ) else $error("wrong control state at reset release");

  a_left_hi_level: assert property (
    (wr_left && reg_wdata[7:4] <= 4'h8)
      |=> lmix_second_left_input_conn
        && lmix_second_left_input_atten == $past(reg_wdata[7:4])
  ) else $error("left mix second left level not applied");

  a_left_lo_off: assert property (
    (wr_left && reg_wdata[3:0] == 4'hF)
      |=> !lmix_second_right_input_conn
  ) else $error("left mix second right input still connected");

  a_right_hi_off: assert property (
    (wr_right && reg_wdata[7:4] == 4'hF)
      |=> !rmix_second_left_input_conn
  ) else $error("right mix second left input still connected");

  a_right_lo_level: assert property (
    (wr_right && reg_wdata[3:0] <= 4'h8)
      |=> rmix_second_right_input_conn
        && rmix_second_right_input_atten == $past(reg_wdata[3:0])
  ) else $error("right mix second right level not applied");

  a_left_hi_off: assert property (
    (wr_left && reg_wdata[7:4] == 4'hF)
      |=> !lmix_second_left_input_conn
        && lmix_second_left_input_atten == 4'h0
  ) else $error("left mix second left input still connected");

  a_left_lo_level: assert property (
    (wr_left && reg_wdata[3:0] <= 4'h8)
      |=> lmix_second_right_input_conn
        && lmix_second_right_input_atten == $past(reg_wdata[3:0])
  ) else $error("left mix second right level not applied");

  a_right_hi_level: assert property (
    (wr_right && reg_wdata[7:4] <= 4'h8)
      |=> rmix_second_left_input_conn
        && rmix_second_left_input_atten == $past(reg_wdata[7:4])
  ) else $error("right mix second left level not applied");

  a_right_lo_off: assert property (
    (wr_right && reg_wdata[3:0] == 4'hF)
      |=> !rmix_second_right_input_conn
  ) else $error("right mix second right input still connected");

  a_off_atten_zero: assert property (
    (lmix_second_left_input_conn
       || lmix_second_left_input_atten == 4'h0)
      && (lmix_second_right_input_conn
       || lmix_second_right_input_atten == 4'h0)
      && (rmix_second_left_input_conn
       || rmix_second_left_input_atten == 4'h0)
      && (rmix_second_right_input_conn
       || rmix_second_right_input_atten == 4'h0)
  ) else $error("disconnected input shows nonzero attenuation");

  a_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata)
  ) else $error("read data moved without a read strobe");

  a_gain_read_back: assert property (
    (reg_rd && reg_addr == 7'h10 && !reg_wr)
      |=> reg_rdata == $past(gain_ctrl_reg)
  ) else $error("read back of right gain register wrong");

  a_right_read_back: assert property (
    (reg_rd && reg_addr == 7'h12 && !reg_wr)
      |=> reg_rdata == $past(right_mix_reg)
  ) else $error("read back of right mix register wrong");

  a_unmapped_read: assert property (
    (reg_rd && reg_addr > 7'h12) |=> reg_rdata == agm_pkg::UNMAPPED_RDATA
  ) else $error("unmapped address read back nonzero");

  a_unmapped_write: assert property (
    (reg_wr && reg_addr > 7'h12)
      |=> $stable(gain_ctrl_reg) && $stable(left_mix_reg)
        && $stable(right_mix_reg)
  ) else $error("write to unmapped address changed a register");

  a_conn_matches_code: assert property (
    lmix_second_left_input_conn == (left_mix_reg[7:4] <= 4'h8)
  ) else $error("connect flag disagrees with stored level code");

  a_static_outputs: assert property (
    !reg_wr [*2] |-> $stable(right_amp_gain) && $stable(right_amp_mute)
      && $stable(rmix_second_left_input_atten)
  ) else $error("control outputs moved without a write");

  a_read_back: assert property (
    (reg_rd && reg_addr == 7'h11 && !reg_wr)
      |=> reg_rdata == $past(left_mix_reg)
  ) else $error("read back of left mix register wrong");

  // ---------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------
  c_unmute: cover property (
    wr_gain && !reg_wdata[7] ##1 !right_amp_mute
  );
  c_gain_clamp: cover property (
    wr_gain && reg_wdata[6:0] == 7'h7F ##1 right_amp_gain == 7'h77
  );
  c_all_connected: cover property (
    lmix_second_left_input_conn && lmix_second_right_input_conn
      && rmix_second_left_input_conn && rmix_second_right_input_conn
  );
  c_unmapped_read: cover property (
    reg_rd && reg_addr > 7'h12
  );
  c_left_disconnect: cover property (
    wr_left && reg_wdata == 8'hFF ##1 !lmix_second_left_input_conn
  );

endmodule // agm_regs

// file: hdl/agm_pkg.sv
package agm_pkg;

  // ---------------------------------------------------------------
  // Register map, page 0
  // ---------------------------------------------------------------
  localparam int              ADDR_W              = 7;
  localparam int              DATA_W              = 8;
  localparam logic [6:0]      RIGHT_PGA_GAIN_CTRL = 7'h10;
  localparam logic [6:0]      SECOND_IN_TO_LEFT   = 7'h11;
  localparam logic [6:0]      SECOND_IN_TO_RIGHT  = 7'h12;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int              MUTE_BIT            = 7;
  localparam int              GAIN_MSB            = 6;
  localparam int              GAIN_LSB            = 0;
  localparam int              HI_LVL_MSB          = 7;
  localparam int              HI_LVL_LSB          = 4;
  localparam int              LO_LVL_MSB          = 3;
  localparam int              LO_LVL_LSB          = 0;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0]      GAIN_CTRL_RST       = 8'h80;
  localparam logic [7:0]      MIX_RST             = 8'hFF;
  localparam logic [6:0]      GAIN_MAX_CODE       = 7'h77;
  localparam logic [3:0]      LVL_MAX_CODE        = 4'h8;
  localparam logic [3:0]      LVL_OFF_CODE        = 4'hF;
  localparam logic [7:0]      UNMAPPED_RDATA      = 8'h00;

endpackage

// file: hdl/agm_level_decode.sv
`timescale 1ns/1ps
// Turns a 4-bit input level code into connect flag and attenuation step
module agm_level_decode (
  input  wire logic [3:0] code,
  output logic            connect,
  output logic [3:0]      atten
);

  always_comb begin
    if (code <= agm_pkg::LVL_MAX_CODE) begin
      connect = 1'b1;
      atten   = code;
    end else begin
      // Off code and reserved codes both leave the input unconnected
      connect = 1'b0;
      atten   = 4'h0;
    end
  end

endmodule // agm_level_decode

// file: hdl/agm_gain_sat.sv
`timescale 1ns/1ps
// Clamps a 7-bit half-dB gain code to the top usable step
module agm_gain_sat (
  input  wire logic [6:0] code,
  output logic [6:0]      gain
);

  always_comb begin
    if (code > agm_pkg::GAIN_MAX_CODE) begin
      gain = agm_pkg::GAIN_MAX_CODE;
    end else begin
      gain = code;
    end
  end

endmodule // agm_gain_sat

// file: dv/agm_host_model.sv
`timescale 1ns/1ps
module agm_host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  output logic      [6:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  initial begin
    reg_addr  = 7'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // Level nibbles never carry reserved codes
  function automatic logic [3:0] legal(input logic [3:0] c);
    return (c > 4'h8 && c != 4'hF) ? 4'hF : c;
  endfunction

  task automatic write(input logic [6:0] a, input logic [7:0] d);
    if (a == 7'h11 || a == 7'h12) begin
      d = {legal(d[7:4]), legal(d[3:0])};
    end
    @(posedge mclk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
    reg_addr  = ~a;
  endtask

  task automatic read(input logic [6:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge mclk);
    #1;
    d        = reg_rdata;
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask
endmodule // agm_host_model

// file: dv/agm_regs_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  err_count++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module agm_regs_test;
  logic mclk, rst_n, reg_wr, reg_rd, mute;
  logic [6:0] reg_addr, gain;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [3:0] conn, a0, a1, a2, a3;
  logic [7:0] exp_reg [3];
  logic [31:0] seed;
  int err_count = 0;
  int n_checks = 0;

  agm_host_model host_u (.mclk(mclk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  agm_regs dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .right_amp_mute(mute), .right_amp_gain(gain),
    .lmix_second_left_input_conn(conn[3]),
    .lmix_second_left_input_atten(a3),
    .lmix_second_right_input_conn(conn[2]),
    .lmix_second_right_input_atten(a2),
    .rmix_second_left_input_conn(conn[1]),
    .rmix_second_left_input_atten(a1),
    .rmix_second_right_input_conn(conn[0]),
    .rmix_second_right_input_atten(a0));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [3:0] lg(input logic [3:0] c);
    return (c > 4'h8 && c != 4'hF) ? 4'hF : c;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    if (a == 7'h11 || a == 7'h12) begin
      v = {lg(v[7:4]), lg(v[3:0])};
    end
    host_u.write(a, v);
    if (a >= 7'h10 && a <= 7'h12) begin
      exp_reg[a - 7'h10] = v;
    end
  endtask

  task automatic check_all();
    logic [15:0] lv;
    logic [3:0]  c, at [4];
    logic [6:0]  g;
    lv = {exp_reg[1], exp_reg[2]};
    at = '{a3, a2, a1, a0};
    g = (exp_reg[0][6:0] > 7'h77) ? 7'h77 : exp_reg[0][6:0];
    `CHK("mute", exp_reg[0][7], mute)
    `CHK("gain", g, gain)
    for (int k = 0; k < 4; k++) begin
      c = lv[15 - 4 * k -: 4];
      `CHK("conn", c <= 4'h8, conn[3 - k])
      `CHK("atten", (c <= 4'h8) ? c : 4'h0, at[k])
    end
    for (int i = 0; i < 4; i++) begin
      host_u.read(7'h10 + 7'(i), d);
      `CHK("rdata", (i < 3) ? exp_reg[i] : agm_pkg::UNMAPPED_RDATA, d)
    end
  endtask

  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h2D7276B5;
    rst_n = 1'b0;
    exp_reg = '{8'h80, 8'hFF, 8'hFF};
    repeat (4) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    check_all();
    $display("test reset done");
    foreach (exp_reg[i]) begin
      wr(7'h10, {i[0], 7'h76 + 7'(i)});
      check_all();
    end
    wr(7'h10, 8'h7F);
    check_all();
    for (int c = 0; c < 10; c++) begin
      wr(7'h11, (c < 9) ? {4'(c), 4'(8 - c)} : 8'hFF);
      wr(7'h12, (c < 9) ? {4'(8 - c), 4'(c)} : 8'hFF);
      check_all();
    end
    $display("test corners done");
    repeat (40) begin
      d = 8'(rnd());
      wr(7'h10 + 7'(d[1:0]), 8'(rnd()));
      check_all();
    end
    $display("test random done");
    tally_and_finish();
  end
endmodule // agm_regs_test
